/* File: rtl/standby_pin_clamp_control.sv */
// Standby pin clamp and amplifier-enable control with its register bank
//
// Operation
// - First standby config at 0x18, reset 0xff00.
// - Second standby config at 0x19, reset 0xff00.
// - Bits 15 and 7 reserved, writable.
// - Pin-control bit and high input force OFF.
// - Pin-control clear leaves amplifier enable untouched.
// - Channel pin-control and high input force clamp.
// - Channel pin-control clear leaves channel untouched.
// - Amp hold keeps OFF until software writes ON.
// - Amp hold clear returns ON when input low.
// - Channel hold keeps clamp until software clears.
// - Channel hold clear releases when input low.
// - Low input needed before amplifier returns ON.
// - Low input needed before channel leaves clamp.
// - Pin clamp sets the channel clamp bit.
// - Amp control bit reads actual output state.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module standby_pin_clamp_control #(
    parameter int AddrWidth = 10
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [AddrWidth-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic standbyInputOne,
    input wire logic standbyInputTwo,
    output logic amplifierEnableOutput,
    output logic [standby_clamp_pkg::ChannelCount-1:0] channelClamp
);
    localparam int NumInputs = 2;
    localparam int Ch = standby_clamp_pkg::ChannelCount;

    standby_clamp_pkg::reg_word_t cfg_q [NumInputs];
    standby_clamp_pkg::reg_word_t cfg_d [NumInputs];
    standby_clamp_pkg::reg_word_t clampCfg_q;
    standby_clamp_pkg::reg_word_t clampCfg_d;
    standby_clamp_pkg::reg_word_t clampSw;
    standby_clamp_pkg::reg_word_t clampReadWord;
    logic ampOut_q;
    logic ampOut_d;
    logic [Ch-1:0] chClamp_q;
    logic [Ch-1:0] chClamp_d;
    logic [NumInputs-1:0] cfgWr;
    logic [NumInputs-1:0] cfgHit;
    logic [NumInputs-1:0] standbyPins;
    logic [Ch-1:0] pinClampVec [NumInputs];
    logic [Ch-1:0] stickyClampVec [NumInputs];
    logic [NumInputs-1:0] pinOffVec;
    logic [NumInputs-1:0] stickyOffVec;
    logic [NumInputs-1:0] ampEnVec;
    logic [Ch-1:0] chEnVec [NumInputs];
    logic [Ch-1:0] pinClampAll;
    logic [Ch-1:0] stickyClampAll;
    logic [Ch-1:0] chEnAll;
    logic pinOffAny;
    logic stickyOffAny;
    logic ampEnAny;
    logic clampWr;
    logic clampHit;

    reg_access_if regBus ();
    standby_src_if src [NumInputs] ();

    // True when the captured index selects the given register
    function automatic logic indexHits(
        input logic [standby_clamp_pkg::IndexWidth-1:0] idx,
        input logic [standby_clamp_pkg::IndexWidth-1:0] target
    );
        indexHits = (idx == target);
    endfunction

    // Bus front end
    ahb_reg_slave #(
        .AddrWidth(AddrWidth)
    ) u_bus (
        .ref_clk(ref_clk),
        .reset(reset),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .regs(regBus.bus)
    );

    assign standbyPins = {standbyInputTwo, standbyInputOne};

    // One source per standby input, each with its own config register
    for (genvar g = 0; g < NumInputs; g++) begin : g_src
        standby_source u_src (
            .ref_clk(ref_clk),
            .reset(reset),
            .standbyPin(standbyPins[g]),
            .port(src[g].source)
        );
        assign src[g].cfg = cfg_q[g];
        assign pinClampVec[g] = src[g].pinClamp;
        assign stickyClampVec[g] = src[g].stickyClamp;
        assign pinOffVec[g] = src[g].pinOff;
        assign stickyOffVec[g] = src[g].stickyOff;
        assign ampEnVec[g] = cfg_q[g][standby_clamp_pkg::AmpPinBit];
        assign chEnVec[g] = cfg_q[g][Ch-1:0];
        assign cfgHit[g] = indexHits(regBus.index,
            standby_clamp_pkg::StandbyOneIndex
            + standby_clamp_pkg::IndexWidth'(g));
        assign cfgWr[g] = regBus.wrEn & cfgHit[g];
        // All bits written as given, reserved ones included
        assign cfg_d[g] = cfgWr[g] ? regBus.wdata : cfg_q[g];

        // Config register storage
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                cfg_q[g] <= standby_clamp_pkg::StandbyCfgReset;
            end else begin
                cfg_q[g] <= cfg_d[g];
            end
        end
    end

    // Requests of both inputs merged
    always_comb begin
        pinClampAll = '0;
        stickyClampAll = '0;
        chEnAll = '0;
        for (int i = 0; i < NumInputs; i++) begin
            pinClampAll = pinClampAll | pinClampVec[i];
            stickyClampAll = stickyClampAll | stickyClampVec[i];
            chEnAll = chEnAll | chEnVec[i];
        end
    end

    assign pinOffAny = |pinOffVec;
    assign stickyOffAny = |stickyOffVec;
    assign ampEnAny = |ampEnVec;

    // Clamp register: software value, then hardware clamp sets and amp hold clears win over software
    assign clampHit = indexHits(regBus.index, standby_clamp_pkg::ClampCfgIndex);
    assign clampWr = regBus.wrEn & clampHit;
    assign clampSw = clampWr ? regBus.wdata : clampCfg_q;
    assign clampCfg_d = {clampSw[15:7],
        clampSw[standby_clamp_pkg::AmpCtrlBit] & ~stickyOffAny,
        clampSw[Ch-1:0] | stickyClampAll};

    // Outputs: stored state ORed or gated by live pin requests
    assign chClamp_d = clampCfg_d[Ch-1:0] | pinClampAll;
    assign ampOut_d = clampCfg_d[standby_clamp_pkg::AmpCtrlBit] & ~pinOffAny;

    // Clamp register and output flops
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clampCfg_q <= standby_clamp_pkg::ClampCfgReset;
            chClamp_q <= standby_clamp_pkg::ClampCfgReset[Ch-1:0];
            ampOut_q <= standby_clamp_pkg::ClampCfgReset[standby_clamp_pkg::AmpCtrlBit];
        end else begin
            clampCfg_q <= clampCfg_d;
            chClamp_q <= chClamp_d;
            ampOut_q <= ampOut_d;
        end
    end

    assign channelClamp = chClamp_q;
    assign amplifierEnableOutput = ampOut_q;

    // Read view: clamp bits show pin clamps, amp bit shows the output state
    assign clampReadWord = {clampCfg_q[15:7], ampOut_q,
        clampCfg_q[Ch-1:0] | chClamp_q};
    assign regBus.rdata = clampHit ? clampReadWord
        : cfgHit[0] ? cfg_q[0]
        : cfgHit[1] ? cfg_q[1]
        : '0;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    chk_first_reset: assert property (
        $past(reset) |-> cfg_q[0] == standby_clamp_pkg::StandbyCfgReset
            && !amplifierEnableOutput)
        else $error("first standby config not at reset value");

    chk_second_reset: assert property (
        $past(reset) |-> cfg_q[1] == standby_clamp_pkg::StandbyCfgReset)
        else $error("second standby config not at reset value");

    chk_reserved_write: assert property (
        cfgWr[0] |=> cfg_q[0][15] == $past(regBus.wdata[15])
            && cfg_q[0][7] == $past(regBus.wdata[7]))
        else $error("reserved bits not written");

    chk_amp_forced_off: assert property (
        pinOffAny |=> !amplifierEnableOutput)
        else $error("amplifier enable not forced off");

    chk_amp_unaffected: assert property (
        (!ampEnAny && !clampWr) |=> amplifierEnableOutput == $past(clampCfg_q[6]))
        else $error("amplifier enable moved without pin control");

    chk_channel_forced: assert property (
        pinClampAll != '0 |=> (channelClamp & $past(pinClampAll)) == $past(pinClampAll))
        else $error("enabled channel not clamped");

    chk_channel_unaffected: assert property (
        (chEnAll == '0 && !clampWr) |=> channelClamp == $past(clampCfg_q[5:0]))
        else $error("channel moved without pin control");

    chk_amp_hold_off: assert property (
        stickyOffAny ##1 (!pinOffAny && !clampWr) |=> !amplifierEnableOutput)
        else $error("amplifier left held off state without write");

    chk_amp_direct_on: assert property (
        (!pinOffAny && !stickyOffAny && !clampWr && clampCfg_q[6])
            |=> amplifierEnableOutput)
        else $error("amplifier not returned on directly");

    chk_channel_hold: assert property (
        stickyClampAll != '0
            |=> (clampCfg_q[5:0] & $past(stickyClampAll)) == $past(stickyClampAll))
        else $error("held channel clamp bit not set");

    chk_channel_release: assert property (
        (pinClampAll == '0 && !clampWr && clampCfg_q[5:0] == '0) |=> channelClamp == '0)
        else $error("channel not released directly");

    chk_amp_needs_low: assert property (
        amplifierEnableOutput |-> !$past(pinOffAny))
        else $error("amplifier on while pin still forces off");

    chk_clamp_needs_low: assert property (
        pinClampAll != '0 ##1 pinClampAll != '0
            |-> (channelClamp & $past(pinClampAll)) == $past(pinClampAll))
        else $error("channel released while pin still high");

    chk_clamp_bit_view: assert property (
        chClamp_q != '0 |-> (clampReadWord[5:0] & chClamp_q) == chClamp_q)
        else $error("clamped channel reads as unclamped");

    chk_amp_read_view: assert property (
        clampReadWord[6] == amplifierEnableOutput)
        else $error("amplifier bit does not read output state");

    chk_or_combine: assert property (
        (pinClampVec[0] != '0 || pinClampVec[1] != '0) |=> channelClamp != '0)
        else $error("clamp source lost in merge");

    // Register storage, pin paths, software paths and source merge, end to end
    chk_one_write_lands: assert property (
        cfgWr[0] |=> cfg_q[0] == $past(regBus.wdata))
        else $error("first standby config write lost");

    chk_two_write_lands: assert property (
        cfgWr[1] |=> cfg_q[1] == $past(regBus.wdata))
        else $error("second standby config write lost");

    chk_one_cfg_holds: assert property (
        !cfgWr[0] |=> cfg_q[0] == $past(cfg_q[0]))
        else $error("first standby config changed without write");

    chk_two_cfg_holds: assert property (
        !cfgWr[1] |=> cfg_q[1] == $past(cfg_q[1]))
        else $error("second standby config changed without write");

    chk_reserved_two: assert property (
        cfgWr[1] |=> cfg_q[1][15] == $past(regBus.wdata[15])
            && cfg_q[1][7] == $past(regBus.wdata[7]))
        else $error("reserved bits of second config not written");

    chk_pin_one_off: assert property (
        standbyInputOne ##1 cfg_q[0][standby_clamp_pkg::AmpPinBit] |=> !amplifierEnableOutput)
        else $error("first pin did not force amplifier off");

    chk_amp_free_on: assert property (
        (!ampEnAny && clampCfg_q[6] && !clampWr) |=> amplifierEnableOutput)
        else $error("amplifier dropped without pin control");

    chk_pin_two_clamp: assert property (
        standbyInputTwo ##1 cfg_q[1][0] |=> channelClamp[0])
        else $error("second pin did not clamp pair a");

    chk_pin_one_clamp: assert property (
        standbyInputOne ##1 cfg_q[0][5] |=> channelClamp[5])
        else $error("first pin did not clamp aux channel four");

    chk_disabled_channel: assert property (
        (!chEnAll[0] && !clampCfg_q[0] && !clampWr) |=> !channelClamp[0])
        else $error("disabled channel clamped");

    chk_amp_stays_off: assert property (
        (!clampCfg_q[6] && !clampWr) |=> !amplifierEnableOutput)
        else $error("amplifier turned on without write");

    chk_held_bits_kept: assert property (
        !clampWr |=> (clampCfg_q[5:0] & $past(clampCfg_q[5:0])) == $past(clampCfg_q[5:0]))
        else $error("stored clamp bit cleared without write");

    chk_pin_clamp_kept: assert property (
        (~channelClamp & $past(pinClampAll)) == 6'h00)
        else $error("channel left clamp while pin requested it");

    chk_pin_clamp_read: assert property (
        pinClampAll != 6'h00
            |=> (clampReadWord[5:0] & $past(pinClampAll)) == $past(pinClampAll))
        else $error("pin clamp not shown in clamp bits");

    chk_sw_amp_on: assert property (
        (clampWr && regBus.wdata[6] && !stickyOffAny && !pinOffAny) |=> amplifierEnableOutput)
        else $error("software write did not turn amplifier on");

    chk_sw_clamp_clear: assert property (
        (clampWr && regBus.wdata[5:0] == 6'h00 && stickyClampAll == 6'h00)
            |=> clampCfg_q[5:0] == 6'h00)
        else $error("software clear of clamp bits lost");

    chk_level_one: assert property (
        !$past(reset) |-> src[0].level == $past(standbyInputOne))
        else $error("first pin level not sampled");

    chk_level_two: assert property (
        !$past(reset) |-> src[1].level == $past(standbyInputTwo))
        else $error("second pin level not sampled");

    chk_or_second: assert property (
        pinClampVec[1] != 6'h00
            |=> (channelClamp & $past(pinClampVec[1])) == $past(pinClampVec[1]))
        else $error("second source clamp lost in merge");

    chk_or_amp: assert property (
        pinOffVec[1] |=> !amplifierEnableOutput)
        else $error("second source amplifier request lost");

endmodule

/* File: rtl/standby_clamp_pkg.sv */
// Shared constants and types for the standby pin clamp control block
package standby_clamp_pkg;
    localparam int DataWidth = 16;
    localparam int BusWidth = 32;
    localparam int IndexWidth = 8;
    localparam int ChannelCount = 6;
    // Register indices; byte address is four times the index
    localparam logic [7:0] ClampCfgIndex = 8'h17;
    localparam logic [7:0] StandbyOneIndex = 8'h18;
    localparam logic [7:0] StandbyTwoIndex = 8'h19;
    // Values after reset
    localparam logic [15:0] ClampCfgReset = 16'h003f;
    localparam logic [15:0] StandbyCfgReset = 16'hff00;
    // Field positions
    localparam int AmpPinBit = 6;
    localparam int AmpHoldBit = 14;
    localparam int HoldLsb = 8;
    localparam int AmpCtrlBit = 6;
    localparam int RsvdHoldBit = 15;
    localparam int RsvdPinBit = 7;
    typedef logic [DataWidth-1:0] reg_word_t;
    typedef enum logic [1:0] {
        BusIdle = 2'b00,
        BusWrite = 2'b01,
        BusReadWait = 2'b10,
        BusReadDone = 2'b11
    } bus_state_t;
endpackage

/* File: rtl/standby_links_if.sv */
// Interfaces joining the bus front end and the standby sources to the core
`timescale 1ns/1ps
interface reg_access_if;
    logic wrEn;
    logic [standby_clamp_pkg::IndexWidth-1:0] index;
    standby_clamp_pkg::reg_word_t wdata;
    standby_clamp_pkg::reg_word_t rdata;
    modport bus(output wrEn, output index, output wdata, input rdata);
    modport core(input wrEn, input index, input wdata, output rdata);
endinterface

interface standby_src_if;
    standby_clamp_pkg::reg_word_t cfg;
    logic level;
    logic [standby_clamp_pkg::ChannelCount-1:0] pinClamp;
    logic [standby_clamp_pkg::ChannelCount-1:0] stickyClamp;
    logic pinOff;
    logic stickyOff;
    modport source(input cfg, output level, output pinClamp, output stickyClamp,
        output pinOff, output stickyOff);
    modport core(output cfg, input level, input pinClamp, input stickyClamp,
        input pinOff, input stickyOff);
endinterface

/* File: rtl/standby_source.sv */
// One standby input: sampling and per-channel clamp and amplifier requests
`timescale 1ns/1ps
module standby_source (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic standbyPin,
    standby_src_if.source port
);
    logic level_q;

    // Pin sampled once per clock, held as a level
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            level_q <= 1'b0;
        end else begin
            level_q <= standbyPin;
        end
    end

    // Requests gated by pin-control bits, hold bits pick the sticky ones
    assign port.level = level_q;
    assign port.pinClamp = {standby_clamp_pkg::ChannelCount{level_q}}
        & port.cfg[standby_clamp_pkg::ChannelCount-1:0];
    assign port.stickyClamp = port.pinClamp
        & port.cfg[standby_clamp_pkg::HoldLsb +: standby_clamp_pkg::ChannelCount];
    assign port.pinOff = level_q & port.cfg[standby_clamp_pkg::AmpPinBit];
    assign port.stickyOff = port.pinOff & port.cfg[standby_clamp_pkg::AmpHoldBit];
endmodule

/* File: rtl/ahb_reg_slave.sv */
// AHB-Lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module ahb_reg_slave #(
    parameter int AddrWidth = 10
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [AddrWidth-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    reg_access_if.bus regs
);
    standby_clamp_pkg::bus_state_t state_q;
    standby_clamp_pkg::bus_state_t state_d;
    logic [standby_clamp_pkg::IndexWidth-1:0] index_q;
    logic [31:0] hrdata_q;
    wire addrPhase;

    if (AddrWidth < standby_clamp_pkg::IndexWidth + 2) begin : g_chk
        $error("AddrWidth too small for the register indices");
    end

    // Address phase accepted; hsize unused, only word transfers occur
    assign addrPhase = hsel & htrans[1] & hready;
    assign state_d = addrPhase ? (hwrite ? standby_clamp_pkg::BusWrite
        : standby_clamp_pkg::BusReadWait)
        : (state_q == standby_clamp_pkg::BusReadWait) ? standby_clamp_pkg::BusReadDone
        : standby_clamp_pkg::BusIdle;

    // Phase tracking and read capture
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= standby_clamp_pkg::BusIdle;
            index_q <= '0;
            hrdata_q <= '0;
        end else begin
            state_q <= state_d;
            if (addrPhase) begin
                index_q <= haddr[standby_clamp_pkg::IndexWidth+1:2];
            end
            if (state_q == standby_clamp_pkg::BusReadWait) begin
                hrdata_q <= {16'h0000, regs.rdata};
            end
        end
    end

    // Bus answers and core strobes
    assign hreadyout = (state_q != standby_clamp_pkg::BusReadWait);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign regs.wrEn = (state_q == standby_clamp_pkg::BusWrite);
    assign regs.index = index_q;
    assign regs.wdata = hwdata[standby_clamp_pkg::DataWidth-1:0];
endmodule

/* File: testbench/standby_pin_driver.sv */
// Host-side model that drives the two standby pins
`timescale 1ns/1ps
module standby_pin_driver (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic levelOne,
    input wire logic levelTwo,
    output logic pinOne,
    output logic pinTwo
);
    // Pins move just after an edge, low through reset, held as levels
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pinOne <= 1'b0;
            pinTwo <= 1'b0;
        end else begin
            pinOne <= levelOne;
            pinTwo <= levelTwo;
        end
    end
endmodule

/* File: testbench/standby_pin_clamp_control_bench.sv */
// Self-checking bench for the standby pin clamp control block
`timescale 1ns/1ps
module standby_pin_clamp_control_bench;
    localparam logic [9:0] ClampAddr = {standby_clamp_pkg::ClampCfgIndex, 2'b00};
    localparam logic [9:0] OneAddr = {standby_clamp_pkg::StandbyOneIndex, 2'b00};
    localparam logic [9:0] TwoAddr = {standby_clamp_pkg::StandbyTwoIndex, 2'b00};
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [9:0] haddr = 10'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic levelOne = 1'b0;
    logic levelTwo = 1'b0;
    logic pinOne;
    logic pinTwo;
    logic ampOut;
    logic [5:0] clampOut;
    logic [31:0] seed = 32'h88fa0301;
    logic [31:0] rd;
    int failures = 0;
    int total_checks = 0;

    // Clock at 200 MHz
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    standby_pin_driver standby_pin_driver_inst (
        .ref_clk(ref_clk), .reset(reset), .levelOne(levelOne), .levelTwo(levelTwo),
        .pinOne(pinOne), .pinTwo(pinTwo)
    );

    standby_pin_clamp_control #(.AddrWidth(10)) standby_pin_clamp_control_inst (
        .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .standbyInputOne(pinOne), .standbyInputTwo(pinTwo),
        .amplifierEnableOutput(ampOut), .channelClamp(clampOut)
    );

    // Next random value
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Register word as read back over the bus
    function automatic logic [31:0] regView(input logic [31:0] w);
        return {16'h0000, w[15:0]};
    endfunction

    // Verdict and end of run
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded wait for hready sampled high
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                failures++;
                print_verdict();
            end
            @(posedge ref_clk);
        end
    endtask

    // One single word transfer
    task automatic bus(input logic wr, input logic [9:0] addr, input logic [31:0] wdata);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= addr;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        wait_ready();
        rd = hrdata;
        check("response", {31'h0, hresp}, 32'h0);
    endtask

    // Read and compare
    task automatic rdchk(input string what, input logic [9:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0);
        check(what, rd, exp);
    endtask

    // Compare both outputs
    task automatic outchk(input logic amp, input logic [5:0] clamp);
        check("amp enable", {31'h0, ampOut}, {31'h0, amp});
        check("clamp", {26'h0, clampOut}, {26'h0, clamp});
    endtask

    // Set pin levels and let them settle
    task automatic pins(input logic a, input logic b);
        levelOne <= a;
        levelTwo <= b;
        repeat (6) @(posedge ref_clk);
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        outchk(1'b0, 6'h3f);
        rdchk("clamp cfg", ClampAddr, 32'h3f);
        rdchk("cfg one", OneAddr, 32'hff00);
        rdchk("cfg two", TwoAddr, 32'hff00);
        bus(1'b1, 10'h070, 32'hffff);
        rdchk("unmapped", 10'h070, 32'h0);
        bus(1'b1, OneAddr, 32'h8080);
        rdchk("reserved", OneAddr, 32'h8080);
        // Random configurations read back whole
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            bus(1'b1, i[0] ? TwoAddr : OneAddr, seed);
            rdchk("random cfg", i[0] ? TwoAddr : OneAddr, regView(seed));
        end
        bus(1'b1, ClampAddr, 32'h40);
        repeat (3) @(posedge ref_clk);
        outchk(1'b1, 6'h00);
        rdchk("amp read", ClampAddr, 32'h40);
        // Direct release with hold bits clear
        bus(1'b1, OneAddr, 32'h0041);
        bus(1'b1, TwoAddr, 32'h0000);
        pins(1'b1, 1'b0);
        outchk(1'b0, 6'h01);
        rdchk("pin clamp read", ClampAddr, 32'h01);
        pins(1'b0, 1'b0);
        outchk(1'b1, 6'h00);
        // Held release needs software
        bus(1'b1, OneAddr, 32'h4242);
        pins(1'b1, 1'b0);
        outchk(1'b0, 6'h02);
        pins(1'b0, 1'b0);
        outchk(1'b0, 6'h02);
        rdchk("held read", ClampAddr, 32'h02);
        bus(1'b1, ClampAddr, 32'h40);
        repeat (3) @(posedge ref_clk);
        outchk(1'b1, 6'h00);
        // Second pin and combination of sources
        bus(1'b1, OneAddr, 32'h0001);
        bus(1'b1, TwoAddr, 32'h0004);
        pins(1'b0, 1'b1);
        outchk(1'b1, 6'h04);
        pins(1'b1, 1'b1);
        outchk(1'b1, 6'h05);
        pins(1'b1, 1'b0);
        outchk(1'b1, 6'h01);
        pins(1'b0, 1'b0);
        outchk(1'b1, 6'h00);
        // Held clamp from the second input alone
        bus(1'b1, TwoAddr, 32'h0808);
        pins(1'b0, 1'b1);
        pins(1'b0, 1'b0);
        outchk(1'b1, 6'h08);
        bus(1'b1, ClampAddr, 32'h42);
        repeat (3) @(posedge ref_clk);
        outchk(1'b1, 6'h02);
        print_verdict();
    end
endmodule
